/* File: design/tsa_consts.svh */
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH
`define TSA_GRP_DATA 2'h0
`define TSA_GRP_SEL 2'h1
`define TSA_IDX_CTRL0 4'h8
`define TSA_IDX_CTRL1 4'h9
`define TSA_IDX_MASK 4'hA
`define TSA_IDX_STAT 4'hB
`define TSA_IDX_ACK 4'hC
`define TSA_SYNC_OVERFLOW_IRQ_POS 4
`define TSA_SEL_BITS 8'h9F
`define TSA_CTRL_BITS 8'h3F
`define TSA_RST_DATA 8'h00
`define TSA_RST_SEL 8'h00
`define TSA_RST_CTRL 8'h00
`define TSA_RST_MASK 8'hFF
`define TSA_RST_STAT 8'h00
`define TSA_ARB_SLOT 5'h0B
`define TSA_SLOT_BITS 8'h08
`define TSA_LEAD_P0 8'h02
`define TSA_LEAD_P1 8'h01
`define TSA_LAST_BIT 3'h7
`endif

/* File: design/tsa_pkg.sv */
package tsa_pkg;
  typedef struct packed {
    logic port_sel_bit;
    logic [1:0] unused;
    logic [4:0] slot_num_field;
  } slot_port_sel_t;
  typedef struct packed {
    logic [1:0] unused;
    logic arb_slot_monitor_en;
    logic swap;
    logic out_enable_odd;
    logic out_enable_even;
    logic in_enable_odd;
    logic in_enable_even;
  } pair_ctrl_t;
endpackage

/* File: design/timeslot_access_loop_unit.sv */
// Contract
// [R1] Swap exchanges input enables within a pair; output enables stay put.
// [R2] Loop captures a slot and drives it in the same slot next frame.
// [R3] Shift to a slot two or more later completes within the frame.
// [R4] Shift to the next or an earlier slot is output next frame.
// [R5] Looping and shifting run every frame with no host action.
// [R6] Host pairs even registers with even slots, odd with odd, when monitoring.
// [R7] With one internal user, host may choose pair slots freely.
// [R8] Arbitration monitor makes the even register capture slot 11.
// [R9] Host sets even selection to 08 or 88 for arbitration monitoring.
// [R10] Slot 11 and slot 3 may be captured together on both lines.
// [R11] Transfer event two bits after slot for port 0, one for port 1.
// [R12] One bit period equals two double-rate clock periods.
// [R13] Four maskable transfer/overflow pairs reported in one status register.
// [R14] Overflow fires for its own enabled, unacknowledged transfer event.
// [R15] Own transfer masked: overflow fires for any other missed event.
// [R16] No transfer event enabled means no overflow at all.
// [R17] Both enabled: each overflow follows only its own transfer event.
// [R18] Transfer event needs the register's input enabled.
// [R19] Overflow event needs the register's output enabled.
// [R20] Host acknowledges before the deadline ahead of the selected slot.
// [R21] Swap takes input slot and port from the partner's selection.
// [R22] Disabled input keeps the stored value for output.
// [R23] Host writes are driven at the next selected output slot.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tsa_consts.svh"
module timeslot_access_loop_unit (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic double_rate_clock_i,
  input wire logic frame_sync_i,
  input wire logic upstream_line_i,
  output logic upstream_line_o,
  output logic upstream_line_oe_o,
  input wire logic downstream_line_i,
  output logic downstream_line_o,
  output logic downstream_line_oe_o
);
  logic [3:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [8:0] cnt_ff;
  logic fpend_ff, tick_ff;
  tsa_pkg::slot_port_sel_t sel_ff [4];
  tsa_pkg::pair_ctrl_t ctrl_ff [2];
  logic [7:0] data_ff [4];
  logic [7:0] shr_ff [4];
  logic [7:0] obuf_ff [4];
  logic [3:0] pend_ff;
  logic [7:0] mask_ff, stat_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic up_ff, up_oe_ff, dn_ff, dn_oe_ff;

  // Pin synchroniser: a level counts once stages two and three agree
  wire [3:0] nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
  wire dcl_rise = nxt_filt[0] & ~filt_ff[0];
  wire fsc_rise = nxt_filt[1] & ~filt_ff[1];
  wire [8:0] nxt_cnt = fpend_ff ? 9'h000 : 9'(cnt_ff + 9'h001);
  // Bit position and half-bit phase; a bit spans two dcl periods
  wire start = tick_ff & ~cnt_ff[0]; // R12
  wire samp = tick_ff & cnt_ff[0]; // R12
  wire [7:0] pos = cnt_ff[8:1];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 4'h0;
      filt_ff <= 4'h0;
      cnt_ff <= 9'h000;
      fpend_ff <= 1'h0;
      tick_ff <= 1'h0;
    end else begin
      s1_ff <= {downstream_line_i, upstream_line_i,
                frame_sync_i, double_rate_clock_i};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
      tick_ff <= dcl_rise;
      if (dcl_rise) begin
        cnt_ff <= nxt_cnt;
      end
      if (fsc_rise) begin
        fpend_ff <= 1'h1;
      end else if (dcl_rise) begin
        fpend_ff <= 1'h0;
      end
    end
  end

  // Bus decode; every request is answered one cycle after it is seen
  wire [3:0] idx = avs_address_i[5:2];
  wire commit = avs_write_i & ~wait_ff & avs_byteenable_i[0];
  wire [7:0] wbyte = avs_writedata_i[7:0];
  wire wr_sel = commit & (idx[3:2] == `TSA_GRP_SEL);
  wire wr_ctrl = commit & (idx[3:1] == 3'(`TSA_IDX_CTRL0 >> 1));
  wire wr_mask = commit & (idx == `TSA_IDX_MASK);
  wire wr_stat = commit & (idx == `TSA_IDX_STAT);
  wire wr_ack = commit & (idx == `TSA_IDX_ACK);
  wire [7:0] rd_byte =
    (idx[3:2] == `TSA_GRP_DATA) ? data_ff[idx[1:0]] :
    (idx[3:2] == `TSA_GRP_SEL) ? sel_ff[idx[1:0]] :
    (idx == `TSA_IDX_CTRL0) ? ctrl_ff[0] :
    (idx == `TSA_IDX_CTRL1) ? ctrl_ff[1] :
    (idx == `TSA_IDX_MASK) ? mask_ff :
    (idx == `TSA_IDX_STAT) ? stat_ff :
    (idx == `TSA_IDX_ACK) ? {4'h0, pend_ff} : 8'h00;

  wire [3:0] in_en, out_en, sti_en, sync_overflow_irq_en, in_hit, out_hit;
  wire [3:0] sti_evt, miss, sync_overflow_irq_fire, wr_data, ack_wr;
  wire [3:0] lin, up_drv, dn_drv, obit, at_load;

  for (genvar g = 0; g < 4; g++) begin : g_reg
    tsa_pkg::pair_ctrl_t c;
    tsa_pkg::slot_port_sel_t isel;
    wire [1:0] ien;
    wire [1:0] oen;
    wire [4:0] islot;
    wire [7:0] base;
    wire [7:0] lead;
    wire [7:0] load_pos;
    wire [7:0] sti_pos;
    wire [3:0] who;
    assign c = ctrl_ff[g/2];
    assign ien = {c.in_enable_odd, c.in_enable_even};
    assign oen = {c.out_enable_odd, c.out_enable_even};
    assign in_en[g] = c.swap ? ien[1-g%2] : ien[g%2]; // R1
    assign out_en[g] = oen[g%2]; // R1
    assign isel = c.swap ? sel_ff[g^1] : sel_ff[g]; // R21
    // Even register may watch the arbitration slot; the odd one is free
    assign islot = (c.arb_slot_monitor_en && g%2 == 0) ?
                   `TSA_ARB_SLOT : isel.slot_num_field; // R8 R10
    assign lin[g] = isel.port_sel_bit ? filt_ff[3] : filt_ff[2];
    assign in_hit[g] = pos[7:3] == islot;
    assign out_hit[g] = pos[7:3] == sel_ff[g].slot_num_field;
    assign base = {sel_ff[g].slot_num_field, 3'h0};
    assign lead = sel_ff[g].port_sel_bit ? `TSA_LEAD_P1 : `TSA_LEAD_P0;
    // Wraps modulo one frame of 256 bits
    assign load_pos = 8'(base - lead);
    assign sti_pos = 8'(base + `TSA_SLOT_BITS + lead); // R11
    assign at_load[g] = start && pos == load_pos;
    assign sti_en[g] = in_en[g] & ~mask_ff[g]; // R18
    assign sync_overflow_irq_en[g] = out_en[g] & ~mask_ff[`TSA_SYNC_OVERFLOW_IRQ_POS + g]; // R19
    assign sti_evt[g] = start && pos == sti_pos && sti_en[g]; // R11 R13
    assign wr_data[g] = commit && idx == 4'(g);
    assign ack_wr[g] = wr_ack & wbyte[g];
    // A late acknowledge in the deadline cycle still counts
    assign miss[g] = at_load[g] & pend_ff[g] & ~ack_wr[g]; // R14 R20
    assign who = sti_en[g] ? 4'(1 << g) : 4'hF; // R15 R17
    assign sync_overflow_irq_fire[g] = sync_overflow_irq_en[g] & (|(miss & who)); // R14 R15 R16
    assign up_drv[g] = out_hit[g] & out_en[g] & sel_ff[g].port_sel_bit;
    assign dn_drv[g] = out_hit[g] & out_en[g] & ~sel_ff[g].port_sel_bit;
    assign obit[g] = obuf_ff[g][3'h7 - pos[2:0]];

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        shr_ff[g] <= `TSA_RST_DATA;
        data_ff[g] <= `TSA_RST_DATA;
        obuf_ff[g] <= `TSA_RST_DATA;
        pend_ff[g] <= 1'h0;
      end else begin
        if (samp && in_hit[g]) begin
          shr_ff[g] <= {shr_ff[g][6:0], lin[g]};
        end
        // Capture beats a host write landing in the same cycle
        if (samp && in_hit[g] && pos[2:0] == `TSA_LAST_BIT && in_en[g]) begin
          data_ff[g] <= {shr_ff[g][6:0], lin[g]}; // R2 R5 R22
        end else if (wr_data[g]) begin
          data_ff[g] <= wbyte; // R23
        end
        if (at_load[g]) begin
          obuf_ff[g] <= data_ff[g]; // R3 R4 R5
        end
        if (sti_evt[g]) begin
          pend_ff[g] <= 1'h1;
        end else if (ack_wr[g] || at_load[g]) begin
          pend_ff[g] <= 1'h0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        sel_ff[i] <= `TSA_RST_SEL;
      end
      ctrl_ff[0] <= `TSA_RST_CTRL;
      ctrl_ff[1] <= `TSA_RST_CTRL;
      mask_ff <= `TSA_RST_MASK;
      stat_ff <= `TSA_RST_STAT;
      wait_ff <= 1'h1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      if (wr_sel) begin
        sel_ff[idx[1:0]] <= wbyte & `TSA_SEL_BITS;
      end
      if (wr_ctrl) begin
        ctrl_ff[idx[0]] <= wbyte & `TSA_CTRL_BITS;
      end
      if (wr_mask) begin
        mask_ff <= wbyte;
      end
      // New events win over a write-one-to-clear in the same cycle
      stat_ff <= (stat_ff & ~(wr_stat ? wbyte : 8'h00))
                 | {sync_overflow_irq_fire, sti_evt}; // R13
      if (wait_ff && (avs_read_i || avs_write_i)) begin
        wait_ff <= 1'h0;
        rdata_ff <= {24'h00_0000, rd_byte};
      end else begin
        wait_ff <= 1'h1;
      end
    end
  end

  // Line drivers change only at bit starts and hold in between
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      up_ff <= 1'h0;
      up_oe_ff <= 1'h0;
      dn_ff <= 1'h0;
      dn_oe_ff <= 1'h0;
    end else if (start) begin
      up_ff <= |(up_drv & obit);
      up_oe_ff <= |up_drv; // R2 R23
      dn_ff <= |(dn_drv & obit);
      dn_oe_ff <= |dn_drv; // R2 R23
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign upstream_line_o = up_ff;
  assign upstream_line_oe_o = up_oe_ff;
  assign downstream_line_o = dn_ff;
  assign downstream_line_oe_o = dn_oe_ff;

  // Helpers sampled by the checks below
  wire cap0 = samp & in_hit[0] & (pos[2:0] == `TSA_LAST_BIT);
  wire [7:0] cap_val0 = {shr_ff[0][6:0], lin[0]};
  wire sti_pt0 = start && pos == g_reg[0].sti_pos;
  wire in_en0 = in_en[0];
  wire out_en0 = out_en[0];
  wire miss0 = miss[0];
  wire any_miss = |miss;
  wire sti_en0 = sti_en[0];
  wire idle_irq = (sti_en == 4'h0) && (pend_ff == 4'h0);
  wire new_sync_overflow_irq = |(sync_overflow_irq_fire);
  wire drv_up0 = start & up_drv[0];

  property p_keep;
    @(posedge clock_i) disable iff (rst_i)
    (cap0 && !in_en0 && !wr_data[0]) |=> $stable(data_ff[0]);
  endproperty
  a_keep: assert property (p_keep) // R22
    else $error("data changed with input disabled");

  property p_loop;
    @(posedge clock_i) disable iff (rst_i)
    (cap0 && in_en0) |=> data_ff[0] == $past(cap_val0);
  endproperty
  a_loop: assert property (p_loop) // R2
    else $error("captured slot not stored");

  property p_sti_time;
    @(posedge clock_i) disable iff (rst_i)
    $rose(stat_ff[0]) |-> $past(sti_pt0);
  endproperty
  a_sti_time: assert property (p_sti_time) // R11
    else $error("transfer event at wrong bit");

  property p_sti_in;
    @(posedge clock_i) disable iff (rst_i)
    $rose(stat_ff[0]) |-> $past(in_en0);
  endproperty
  a_sti_in: assert property (p_sti_in) // R18
    else $error("transfer event with input disabled");

  property p_sync_overflow_irq_out;
    @(posedge clock_i) disable iff (rst_i)
    $rose(stat_ff[4]) |-> $past(out_en0);
  endproperty
  a_sync_overflow_irq_out: assert property (p_sync_overflow_irq_out) // R19
    else $error("overflow with output disabled");

  property p_none;
    @(posedge clock_i) disable iff (rst_i)
    idle_irq |-> !new_sync_overflow_irq;
  endproperty
  a_none: assert property (p_none) // R16
    else $error("overflow with no transfer event enabled");

  property p_own;
    @(posedge clock_i) disable iff (rst_i)
    ($rose(stat_ff[4]) && $past(sti_en0)) |-> $past(miss0);
  endproperty
  a_own: assert property (p_own) // R17
    else $error("overflow not tied to own event");

  property p_other;
    @(posedge clock_i) disable iff (rst_i)
    $rose(stat_ff[4]) |-> $past(any_miss);
  endproperty
  a_other: assert property (p_other) // R15
    else $error("overflow without any missed event");

  property p_drive;
    @(posedge clock_i) disable iff (rst_i)
    drv_up0 |=> upstream_line_oe_o ##1 upstream_line_oe_o;
  endproperty
  a_drive: assert property (p_drive) // R23
    else $error("selected output slot not driven");

  property p_bus;
    @(posedge clock_i) disable iff (rst_i)
    (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus request not answered");
endmodule
`default_nettype wire

/* File: tb/tsa_frame_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module tsa_frame_partner (
  output logic dcl_o,
  output logic fsync_o,
  output logic up_line_o,
  output logic dn_line_o,
  input wire logic up_dev_i,
  input wire logic up_oe_i,
  input wire logic dn_dev_i,
  input wire logic dn_oe_i
);
  logic up_drv;
  logic dn_drv;
  logic [7:0] pb;
  logic [7:0] su;
  logic [7:0] sd;
  logic [7:0] seen_up [32];
  logic [7:0] seen_dn [32];
  int frm;
  // Other devices own every slot the block leaves free
  assign up_line_o = up_oe_i ? up_dev_i : up_drv;
  assign dn_line_o = dn_oe_i ? dn_dev_i : dn_drv;
  // Frame number in the data shows which frame a byte came from
  function automatic logic [7:0] pat(input int f, input int s);
    return {f[2:0], s[4:0]};
  endfunction
  initial begin
    dcl_o = 1'h0;
    fsync_o = 1'h0;
    frm = 0;
    up_drv = 1'h0;
    dn_drv = 1'h0;
    su = 8'h00;
    sd = 8'h00;
    #3;
    forever begin
      for (int b = 0; b < 256; b++) begin
        fsync_o = (b == 0);
        #40 dcl_o = 1'h1;
        pb = pat(frm, b / 8);
        up_drv = pb[7 - b % 8];
        dn_drv = ~pb[7 - b % 8];
        #40 dcl_o = 1'h0;
        #40 dcl_o = 1'h1;
        su = {su[6:0], up_line_o};
        sd = {sd[6:0], dn_line_o};
        if (b % 8 == 7) begin
          seen_up[b / 8] = su;
          seen_dn[b / 8] = sd;
        end
        #40 dcl_o = 1'h0;
      end
      frm++;
    end
  end
endmodule
`default_nettype wire

/* File: tb/timeslot_access_loop_unit_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module timeslot_access_loop_unit_tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [5:0] ad = 6'h00;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req, double_rate_clock, fs, up_line, dn_line, up_o, up_oe, dn_o, dn_oe;
  logic [7:0] q;
  int err_total = 0;
  int checked = 0;
  int f;
  logic [7:0] mk [7] = '{8'hfe, 8'h0f, 8'hde, 8'hce, 8'hcc, 8'hdc, 8'h8c};
  logic [7:0] ex [7] = '{8'h01, 8'h00, 8'h21, 8'h31, 8'h33, 8'h23, 8'h73};
  always #5 clk = ~clk;
  timeslot_access_loop_unit DUT (
    .clock_i(clk), .rst_i(rst), .avs_address_i(ad), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .double_rate_clock_i(double_rate_clock), .frame_sync_i(fs),
    .upstream_line_i(up_line), .upstream_line_o(up_o),
    .upstream_line_oe_o(up_oe), .downstream_line_i(dn_line),
    .downstream_line_o(dn_o), .downstream_line_oe_o(dn_oe));
  tsa_frame_partner P (
    .dcl_o(double_rate_clock), .fsync_o(fs), .up_line_o(up_line), .dn_line_o(dn_line),
    .up_dev_i(up_o), .up_oe_i(up_oe), .dn_dev_i(dn_o), .dn_oe_i(dn_oe));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // A slave that never answers is caught by the watchdog
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    ad <= {i, 2'h0};
    wr <= w;
    rd <= ~w;
    wd <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (wait_req !== 1'h0);
    q = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] i, input logic [7:0] e, input string n);
    bus(1'h0, i, 8'h00);
    chk(n, e, q);
  endtask
  // Link frames are not tied to the bus clock, so realign after waiting
  task automatic frames(input int k);
    repeat (k) @(P.frm);
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 13; i++) rc(4'(i), (i == 10) ? 8'hff : 8'h00, "reset");
    bus(1'h1, 4'hf, 8'hab);
    rc(4'hf, 8'h00, "unmapped");
    bus(1'h1, 4'h4, 8'hff);
    rc(4'h4, 8'h9f, "sel bits");
    be <= 4'h0;
    bus(1'h1, 4'ha, 8'h00);
    be <= 4'hf;
    rc(4'ha, 8'hff, "byteenable");
    bus(1'h1, 4'h4, 8'h05);
    bus(1'h1, 4'h5, 8'h1f);
    bus(1'h1, 4'h8, 8'h0f);
    bus(1'h1, 4'h6, 8'h04);
    bus(1'h1, 4'h7, 8'h06);
    bus(1'h1, 4'h9, 8'h1f);
    frames(3);
    f = P.frm - 1;
    chk("loop 5", P.pat(f - 1, 5), P.seen_dn[5]);
    chk("loop 31", P.pat(f - 1, 31), P.seen_dn[31]);
    chk("shift 4 to 6", P.pat(f, 4), P.seen_dn[6]);
    chk("shift 6 to 4", P.pat(f - 1, 6), P.seen_dn[4]);
    // Clear one frame after the mask change so no stale event leaks in
    for (int k = 0; k < 7; k++) begin
      bus(1'h1, 4'ha, mk[k]);
      frames(1);
      bus(1'h1, 4'hb, 8'hff);
      frames(1);
      rc(4'hb, ex[k], "status");
    end
    // Acknowledge well ahead of the deadline: no overflow may follow
    bus(1'h1, 4'ha, 8'hee);
    frames(1);
    rc(4'hc, 8'h01, "pending");
    bus(1'h1, 4'hb, 8'hff);
    bus(1'h1, 4'hc, 8'h01);
    frames(1);
    rc(4'hb, 8'h01, "acked");
    bus(1'h1, 4'ha, 8'hcc);
    bus(1'h1, 4'h4, 8'h08);
    bus(1'h1, 4'h5, 8'h03);
    bus(1'h1, 4'h8, 8'h23);
    frames(1);
    bus(1'h1, 4'hb, 8'hff);
    frames(1);
    f = P.frm - 1;
    rc(4'h0, P.pat(f, 11), "arb slot");
    rc(4'h1, P.pat(f, 3), "slot 3");
    rc(4'hb, 8'h03, "status no out");
    bus(1'h1, 4'h8, 8'h0c);
    bus(1'h1, 4'h4, 8'h85);
    bus(1'h1, 4'h0, 8'h5a);
    bus(1'h1, 4'h1, 8'hc3);
    bus(1'h1, 4'ha, 8'hfe);
    frames(1);
    bus(1'h1, 4'hb, 8'hff);
    frames(1);
    chk("write up 5", 8'h5a, P.seen_up[5]);
    chk("held 3", 8'hc3, P.seen_dn[3]);
    rc(4'h0, 8'h5a, "data 0");
    rc(4'hb, 8'h00, "status in off");
    results();
  end
endmodule
`default_nettype wire
